// ===== inc/boot_pkg.sv
package boot_pkg;

  // ==========================================================
  // Address map
  localparam logic [31:0] INT_MEM_BASE  = 32'h0000_0000; // Internal memory at 0
  localparam logic [31:0] EXT_A_BASE    = 32'h8000_0000; // First external interface
  localparam logic [31:0] CS1_BASE      = 32'h9000_0000; // Chip select region one
  localparam logic [31:0] HPC_ADDR      = 32'h0188_0000; // Host port control register
  localparam int          HPC_INT_BIT   = 1;             // Host-to-core interrupt bit
  localparam logic [31:0] CORE_START_PC = 32'h0000_0000; // Core entry point

  // ==========================================================
  // Boot copy sizing
  localparam int          ROM_BYTES     = 1024;          // Bytes copied in ROM boot
  localparam logic [9:0]  ROM_LAST_BYTE = 10'h3FF;       // Index of last byte
  localparam logic [1:0]  LANE_LAST     = 2'h3;          // Last byte of a word
  localparam logic [1:0]  STRAP_SETTLE  = 2'h2;          // Cycles before strap capture

  // ==========================================================
  // Boot mode strap encodings
  typedef enum logic [1:0] {
    MODE_NONE = 2'h0,
    MODE_HOST = 2'h1,
    MODE_ROM  = 2'h2,
    MODE_RSVD = 2'h3
  } boot_mode_t;

  // Device boot states, Gray along capture-copy-run and capture-stall-run
  typedef enum logic [2:0] {
    ST_CAPT  = 3'h0,
    ST_COPY  = 3'h1,
    ST_RUN   = 3'h3,
    ST_STALL = 3'h2
  } boot_st_t;

  // Host end states
  typedef enum logic {
    H_IDLE = 1'b0,
    H_WAIT = 1'b1
  } host_st_t;

endpackage

// ===== inc/host_link_if.sv
`timescale 1ns/1ps
// ==========================================================
// Host access link between the external host and the device
interface host_link_if;
  logic        par_req;  // Request on the parallel host port
  logic        pci_req;  // Request on the PCI port
  logic        wr;       // Write when high, read when low
  logic [31:0] addr;     // Byte address
  logic [31:0] wdata;    // Write data
  logic        ack;      // One-cycle answer from the device
  logic [31:0] rdata;    // Read data, valid with ack

  modport dev (
    input  par_req,
    input  pci_req,
    input  wr,
    input  addr,
    input  wdata,
    output ack,
    output rdata
  );

  modport host (
    output par_req,
    output pci_req,
    output wr,
    output addr,
    output wdata,
    input  ack,
    input  rdata
  );
endinterface

// ===== hw/boot_mode_controller.sv
`timescale 1ns/1ps

module boot_mode_controller #(
  parameter int MEM_AW = 8 // Internal memory word address width
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  host_link_if.dev         link,
  input  wire logic [1:0]  boot_mode_pin,
  input  wire logic        host_sel_pin,
  input  wire logic        big_endian_pin,
  input  wire logic        core_int_clr,
  input  wire logic        rom_ack,
  input  wire logic [7:0]  rom_data,
  output logic             core_stall_r,
  output logic [31:0]      core_start_pc_r,
  output logic             core_int_r,
  output logic             rom_req_r,
  output logic [31:0]      rom_addr_r
);

  // ==========================================================
  // Declarations
  localparam int MEM_WORDS = 1 << MEM_AW;

  logic [1:0]          mode_s1_r, mode_s2_r; // Boot mode synchroniser
  logic                sel_s1_r, sel_s2_r;   // Host port select synchroniser
  logic                end_s1_r, end_s2_r;   // Endian strap synchroniser
  logic [1:0]          settle_r;             // Strap settle counter
  boot_pkg::boot_mode_t mode_r;              // Captured boot mode
  logic                sel_r;                // Captured host path
  logic                big_r;                // Captured byte order
  boot_pkg::boot_st_t  st_r, st_nxt;         // Boot state
  logic                hpc_int_r;            // Host-to-core interrupt bit
  logic [9:0]          byte_cnt_r;           // ROM byte counter
  logic [31:0]         pack_r;               // Partly packed word
  logic                ack_r;                // Link answer
  logic [31:0]         rdata_r;              // Link read data
  logic [31:0]         mem [MEM_WORDS];      // Internal memory

  // ==========================================================
  // Host access decode
  wire        req_sel  = sel_r ? link.pci_req : link.par_req;
  wire        take     = req_sel && !ack_r &&
                         st_r != boot_pkg::ST_CAPT && st_r != boot_pkg::ST_COPY;
  wire        is_int   = link.addr < boot_pkg::EXT_A_BASE;
  wire        is_mem   = is_int && link.addr[31:MEM_AW+2] == '0;
  wire        is_hpc   = link.addr == boot_pkg::HPC_ADDR;
  wire [MEM_AW-1:0] h_idx = link.addr[MEM_AW+1:2];
  wire        host_we  = take && link.wr && is_mem;

  // Interrupt bit set only while clear
  wire        int_set  = take && link.wr && is_hpc &&
                         link.wdata[boot_pkg::HPC_INT_BIT] && !hpc_int_r;
  wire        release_h = int_set && st_r == boot_pkg::ST_STALL &&
                          mode_r == boot_pkg::MODE_HOST;

  // ==========================================================
  // ROM copy decode
  wire        copy_ack = st_r == boot_pkg::ST_COPY && rom_req_r && rom_ack;
  wire [31:0] pack_nxt = big_r ? {pack_r[23:0], rom_data}
                               : {rom_data, pack_r[31:8]};
  wire        word_end = byte_cnt_r[1:0] == boot_pkg::LANE_LAST;
  wire        copy_we  = copy_ack && word_end;
  wire        copy_end = copy_ack && byte_cnt_r == boot_pkg::ROM_LAST_BYTE;
  wire [MEM_AW-1:0] c_idx = MEM_AW'(byte_cnt_r[9:2]);

  // Memory write port, copy and host never active together
  wire              mem_we  = copy_we || host_we;
  wire [MEM_AW-1:0] mem_idx = copy_we ? c_idx : h_idx;
  wire [31:0]       mem_wd  = copy_we ? pack_nxt : link.wdata;

  // Read data selection
  wire [31:0] hpc_val  = 32'(hpc_int_r) << boot_pkg::HPC_INT_BIT;
  wire [31:0] rd_val   = is_mem ? mem[h_idx] : is_hpc ? hpc_val : 32'h0000_0000;

  // ==========================================================
  // Strap synchronisers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_s1_r <= 2'h0;
      mode_s2_r <= 2'h0;
      sel_s1_r  <= 1'b0;
      sel_s2_r  <= 1'b0;
      end_s1_r  <= 1'b0;
      end_s2_r  <= 1'b0;
    end else begin
      mode_s1_r <= boot_mode_pin;
      mode_s2_r <= mode_s1_r;
      sel_s1_r  <= host_sel_pin;
      sel_s2_r  <= sel_s1_r;
      end_s1_r  <= big_endian_pin;
      end_s2_r  <= end_s1_r;
    end
  end

  // ==========================================================
  // Strap capture after release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      settle_r <= 2'h0;
      mode_r   <= boot_pkg::MODE_NONE;
      sel_r    <= 1'b0;
      big_r    <= 1'b0;
    end else if (st_r == boot_pkg::ST_CAPT) begin
      settle_r <= settle_r + 2'h1;
      mode_r   <= boot_pkg::boot_mode_t'(mode_s2_r);
      sel_r    <= sel_s2_r;
      big_r    <= end_s2_r;
    end
  end

  // ==========================================================
  // Boot state selection
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      boot_pkg::ST_CAPT: begin
        if (settle_r == boot_pkg::STRAP_SETTLE) begin
          // Decide on the synchronised strap, mode_r only lands this edge
          case (boot_pkg::boot_mode_t'(mode_s2_r))
            boot_pkg::MODE_HOST: st_nxt = boot_pkg::ST_STALL;
            boot_pkg::MODE_ROM:  st_nxt = boot_pkg::ST_COPY;
            default:             st_nxt = boot_pkg::ST_RUN;
          endcase
        end
      end
      boot_pkg::ST_STALL: begin
        if (release_h) st_nxt = boot_pkg::ST_RUN;
      end
      boot_pkg::ST_COPY: begin
        if (copy_end) st_nxt = boot_pkg::ST_RUN;
      end
      boot_pkg::ST_RUN: begin
        st_nxt = boot_pkg::ST_RUN;
      end
      default: st_nxt = boot_pkg::ST_CAPT;
    endcase
  end

  // ==========================================================
  // Boot state and core control
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r            <= boot_pkg::ST_CAPT;
      core_stall_r    <= 1'b1;
      core_start_pc_r <= boot_pkg::CORE_START_PC;
    end else begin
      st_r            <= st_nxt;
      core_stall_r    <= st_nxt != boot_pkg::ST_RUN;
      core_start_pc_r <= boot_pkg::CORE_START_PC;
    end
  end

  // ==========================================================
  // Host-to-core interrupt bit, set wins over clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hpc_int_r  <= 1'b0;
      core_int_r <= 1'b0;
    end else begin
      if (int_set) begin
        hpc_int_r <= 1'b1;
      end else if (core_int_clr) begin
        hpc_int_r <= 1'b0;
      end
      core_int_r <= int_set && st_r == boot_pkg::ST_RUN;
    end
  end

  // ==========================================================
  // ROM copy sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      byte_cnt_r <= 10'h000;
      pack_r     <= 32'h0000_0000;
      rom_req_r  <= 1'b0;
      rom_addr_r <= boot_pkg::CS1_BASE;
    end else if (st_r == boot_pkg::ST_COPY) begin
      if (copy_ack) begin
        byte_cnt_r <= byte_cnt_r + 10'h001;
        pack_r     <= pack_nxt;
        rom_req_r  <= 1'b0;
        rom_addr_r <= rom_addr_r + 32'h0000_0001;
      end else if (!copy_end) begin
        rom_req_r  <= 1'b1;
      end
    end else begin
      rom_req_r  <= 1'b0;
    end
  end

  // ==========================================================
  // Internal memory, no reset on contents
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_idx] <= mem_wd;
    end
  end

  // ==========================================================
  // Link answer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r   <= take;
      if (take && !link.wr) begin
        rdata_r <= rd_val;
      end
    end
  end

  assign link.ack   = ack_r;
  assign link.rdata = rdata_r;

endmodule

// ===== hw/boot_host_end.sv
`timescale 1ns/1ps
// ==========================================================
// External host: issues accesses and ends the host boot
module boot_host_end (
  input  wire logic        clk,
  input  wire logic        rst_b,
  host_link_if.host        link,
  input  wire logic        use_pci,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [31:0] cmd_addr,
  input  wire logic [31:0] cmd_wdata,
  input  wire logic        finish,
  output logic             busy_r,
  output logic             done_r,
  output logic [31:0]      rdata_r
);

  // ==========================================================
  // Declarations
  boot_pkg::host_st_t st_r;       // Host state
  logic               par_req_r;  // Parallel port request
  logic               pci_req_r;  // PCI request
  logic               wr_r;       // Write flag
  logic [31:0]        addr_r;     // Address
  logic [31:0]        wdata_r;    // Write data

  // Finish becomes a write of the interrupt bit
  wire        start  = st_r == boot_pkg::H_IDLE && (finish || cmd_valid);
  wire [31:0] s_addr = finish ? boot_pkg::HPC_ADDR : cmd_addr;
  wire [31:0] s_data = finish ? (32'h0000_0001 << boot_pkg::HPC_INT_BIT)
                              : cmd_wdata;
  wire        s_wr   = finish || cmd_write;

  // ==========================================================
  // Request and answer sequencing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r      <= boot_pkg::H_IDLE;
      par_req_r <= 1'b0;
      pci_req_r <= 1'b0;
      wr_r      <= 1'b0;
      addr_r    <= 32'h0000_0000;
      wdata_r   <= 32'h0000_0000;
      busy_r    <= 1'b0;
      done_r    <= 1'b0;
      rdata_r   <= 32'h0000_0000;
    end else begin
      done_r <= 1'b0;
      case (st_r)
        boot_pkg::H_IDLE: begin
          if (start) begin
            st_r      <= boot_pkg::H_WAIT;
            par_req_r <= !use_pci;
            pci_req_r <= use_pci;
            wr_r      <= s_wr;
            addr_r    <= s_addr;
            wdata_r   <= s_data;
            busy_r    <= 1'b1;
          end
        end
        boot_pkg::H_WAIT: begin
          if (link.ack) begin
            st_r      <= boot_pkg::H_IDLE;
            par_req_r <= 1'b0;
            pci_req_r <= 1'b0;
            busy_r    <= 1'b0;
            done_r    <= 1'b1;
            rdata_r   <= link.rdata;
          end
        end
        default: st_r <= boot_pkg::H_IDLE;
      endcase
    end
  end

  assign link.par_req = par_req_r;
  assign link.pci_req = pci_req_r;
  assign link.wr      = wr_r;
  assign link.addr    = addr_r;
  assign link.wdata   = wdata_r;

endmodule

// ===== verification/boot_mode_controller_asserts.sv
`timescale 1ns/1ps
// ==========================================================
// Link and boot sequence checks
module boot_mode_controller_asserts (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        par_req,
  input wire logic        pci_req,
  input wire logic        ack,
  input wire logic        core_stall_r,
  input wire logic        core_int_r,
  input wire logic        rom_req_r,
  input wire logic        rom_ack,
  input wire logic [31:0] rom_addr_r
);
  // One clock domain, reset disables all checks
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  chk_ack_single_pulse: assert property (ack |=> !ack)
    else $error("ack held longer than one cycle");
  chk_ack_has_request: assert property ($rose(ack) |-> $past(par_req || pci_req))
    else $error("ack without a request");
  chk_copy_keeps_stall: assert property (rom_req_r |-> core_stall_r)
    else $error("core running during copy");
  chk_copy_blocks_host: assert property (rom_req_r |-> !ack)
    else $error("host answered during copy");
  chk_rom_in_region: assert property (
    rom_req_r |-> rom_addr_r[31:10] == boot_pkg::CS1_BASE[31:10])
    else $error("ROM address outside first 1K of region one");
  chk_rom_addr_step: assert property (
    rom_req_r && rom_ack && rom_addr_r[9:0] != 10'h3FF |=> !rom_req_r ##1
    (rom_req_r && rom_addr_r == $past(rom_addr_r, 2) + 32'h0000_0001))
    else $error("ROM address not stepped by one byte");
  chk_copy_end_release: assert property (
    rom_req_r && rom_ack && rom_addr_r[9:0] == 10'h3FF |=> !core_stall_r && !rom_req_r)
    else $error("core not released after last byte");
  chk_run_stays_run: assert property (!core_stall_r |=> !core_stall_r)
    else $error("running core stalled again");
  chk_int_only_run: assert property (core_int_r |-> !core_stall_r ##1 !core_int_r)
    else $error("core interrupt while stalled or too long");
endmodule

// ===== verification/boot_mode_controller_tb_top.sv
`timescale 1ns/1ps
module boot_mode_controller_tb_top;
  // ==========================================================
  // Stimulus and observed signals
  logic        clk, rst_b, host_sel_pin, big_endian_pin, core_int_clr;
  logic [1:0]  boot_mode_pin;  // Boot mode strap
  logic        rom_ack;        // ROM byte answer
  logic [7:0]  rom_data;       // ROM byte
  logic        use_pci, cmd_valid, cmd_write, finish;
  logic [31:0] cmd_addr, cmd_wdata;
  logic        core_stall_r, core_int_r, rom_req_r, busy_r, done_r;
  logic [31:0] core_start_pc_r, rom_addr_r, rdata_r;
  int          fails, check_count, int_pulses, rom_bytes;

  // ==========================================================
  // Both ends joined by the link
  host_link_if link ();
  boot_mode_controller boot_mode_controller_i (.clk(clk), .rst_b(rst_b), .link(link),
    .boot_mode_pin(boot_mode_pin), .host_sel_pin(host_sel_pin),
    .big_endian_pin(big_endian_pin), .core_int_clr(core_int_clr), .rom_ack(rom_ack),
    .rom_data(rom_data), .core_stall_r(core_stall_r), .core_start_pc_r(core_start_pc_r),
    .core_int_r(core_int_r), .rom_req_r(rom_req_r), .rom_addr_r(rom_addr_r));
  boot_host_end boot_host_end_i (.clk(clk), .rst_b(rst_b), .link(link), .use_pci(use_pci),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .finish(finish), .busy_r(busy_r), .done_r(done_r),
    .rdata_r(rdata_r));
  boot_mode_controller_asserts boot_mode_controller_asserts_i (.clk(clk), .rst_b(rst_b),
    .par_req(link.par_req), .pci_req(link.pci_req), .ack(link.ack),
    .core_stall_r(core_stall_r), .core_int_r(core_int_r), .rom_req_r(rom_req_r),
    .rom_ack(rom_ack), .rom_addr_r(rom_addr_r));

  // Clock at 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ROM answers one cycle after each request; counts bytes and interrupts
  always @(posedge clk) begin
    rom_ack <= rom_req_r && !rom_ack;
    rom_data <= rom_addr_r[7:0] ^ 8'hA5;
    // Counters cleared while reset is held
    if (!rst_b) begin
      rom_bytes <= 0;
      int_pulses <= 0;
    end else begin
      if (rom_ack === 1'b1 && rom_req_r === 1'b1) rom_bytes <= rom_bytes + 1;
      if (core_int_r === 1'b1) int_pulses <= int_pulses + 1;
    end
  end

  // Expected word k of the ROM image in either byte order
  function automatic logic [31:0] rom_word(input logic [7:0] k, input logic big);
    logic [7:0] b [4];
    for (int i = 0; i < 4; i++) b[i] = {k[5:0], i[1:0]} ^ 8'hA5;
    rom_word = big ? {b[0], b[1], b[2], b[3]} : {b[3], b[2], b[1], b[0]};
  endfunction

  // ==========================================================
  // Comparison and closing report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    if (fails == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Reset with straps set; checks reset state before release
  task automatic do_reset(input logic [1:0] mode, input logic sel, input logic big);
    @(posedge clk);
    rst_b <= 1'b0;
    boot_mode_pin <= mode;
    host_sel_pin <= sel;
    big_endian_pin <= big;
    cmd_valid <= 1'b0;
    finish <= 1'b0;
    repeat (20) @(posedge clk);
    #1;
    check(core_stall_r, 1);
    check({rom_req_r, core_int_r, link.ack, busy_r}, 0);
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
  endtask

  // One host access or finish; exp_ok says whether an answer is due
  task automatic host_op(input logic p, input logic w, input logic fin,
                         input logic [31:0] a, input logic exp_ok);
    logic ok;
    ok = 1'b0;
    @(posedge clk);
    use_pci <= p;
    cmd_write <= w;
    cmd_addr <= a;
    cmd_wdata <= a ^ 32'h5A5A_0F0F;
    cmd_valid <= !fin;
    finish <= fin;
    @(posedge clk);
    cmd_valid <= 1'b0;
    finish <= 1'b0;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(posedge clk);
      #1;
      ok = (done_r === 1'b1);
    end
    check(ok, exp_ok);
    if (ok !== exp_ok) end_of_test();
  endtask

  // ==========================================================
  // Host boot on the selected path, then interrupts while running
  task automatic host_boot(input logic sel);
    do_reset(2'h1, sel, 1'b0);
    check(core_stall_r, 1);
    host_op(sel, 1, 0, 32'h0000_0000, 1);
    host_op(sel, 0, 0, 32'h0000_0000, 1);
    check(rdata_r, 32'h5A5A_0F0F);
    host_op(sel, 1, 0, boot_pkg::EXT_A_BASE, 1);
    host_op(sel, 0, 0, boot_pkg::EXT_A_BASE, 1);
    check(rdata_r, 0);
    check(core_stall_r, 1);
    host_op(sel, 0, 1, 0, 1);
    check(core_stall_r, 0);
    check(core_start_pc_r, boot_pkg::CORE_START_PC);
    check(int_pulses, 0);
    host_op(sel, 0, 0, boot_pkg::HPC_ADDR, 1);
    check(rdata_r[boot_pkg::HPC_INT_BIT], 1);
    host_op(sel, 0, 1, 0, 1);
    repeat (2) @(posedge clk);
    check(int_pulses, 0);
    core_int_clr <= 1'b1;
    @(posedge clk);
    core_int_clr <= 1'b0;
    host_op(sel, 0, 1, 0, 1);
    repeat (2) @(posedge clk);
    #1;
    check(int_pulses, 1);
    check(core_stall_r, 0);
    host_op(!sel, 0, 0, 32'h0000_0000, 0);
  endtask

  // No boot, also the spare encoding
  task automatic no_boot(input logic [1:0] mode);
    do_reset(mode, 1'b0, 1'b0);
    check(core_stall_r, 0);
    host_op(0, 0, 1, 0, 1);
    repeat (2) @(posedge clk);
    #1;
    check(int_pulses, 1);
    check(rom_bytes, 0);
  endtask

  // ROM boot copy and packing in the given byte order
  task automatic rom_boot(input logic big);
    int n;
    do_reset(2'h2, 1'b0, big);
    check(core_stall_r, 1);
    for (n = 0; n < 5000 && core_stall_r !== 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
    check(core_stall_r, 0);
    if (core_stall_r !== 1'b0) end_of_test();
    check(rom_bytes, boot_pkg::ROM_BYTES);
    for (int k = 0; k < 256; k += 85) begin
      host_op(0, 0, 0, {22'h0, k[7:0], 2'h0}, 1);
      check(rdata_r, rom_word(k[7:0], big));
    end
  endtask

  // Main sequence
  initial begin
    {rst_b, host_sel_pin, big_endian_pin, core_int_clr, use_pci} = 5'h00;
    {cmd_valid, cmd_write, finish, boot_mode_pin} = 5'h00;
    {cmd_addr, cmd_wdata} = 64'h0;
    {fails, check_count} = 64'h0;
    host_boot(1'b0);
    host_boot(1'b1);
    no_boot(2'h0);
    no_boot(2'h3);
    rom_boot(1'b1);
    rom_boot(1'b0);
    end_of_test();
  end
endmodule
